//--- rdflag_pkg.sv
/*
 * constants, mode type and helper functions for the read-side flag block
 * assumes nothing beyond a simulator or synthesis tool with SystemVerilog
 */
`default_nettype none
package rdflag_pkg;
	// register byte offsets on the apb slave
	localparam logic [7:0]  ADDR_CMD      = 8'h00;
	localparam logic [7:0]  ADDR_AE_OFS   = 8'h04;
	localparam logic [7:0]  ADDR_STATUS   = 8'h08;
	localparam logic [7:0]  ADDR_IRQ_STAT = 8'h0c;
	localparam logic [7:0]  ADDR_IRQ_CLR  = 8'h10;
	localparam logic [7:0]  ADDR_IRQ_EN   = 8'h14;
	// command register layout
	localparam int          CMD_W         = 12;
	localparam logic [11:0] CMD_RESET     = 12'h000;
	localparam int          CMD_AE_SYNC   = 6;
	localparam int          CMD_STRAP_LSB = 6;
	localparam int          CMD_STRAP_MSB = 10;
	localparam logic [4:0]  STRAP_FORCED  = 5'h1f;
	localparam logic [4:0]  STRAP_CLEAR   = 5'h00;
	// interrupt event bits
	localparam int          NUM_EV        = 3;
	localparam int          EV_EMPTY      = 0;
	localparam int          EV_AEMPTY     = 1;
	localparam int          EV_TOKEN      = 2;
	localparam logic [2:0]  IRQ_EN_RESET  = 3'h0;
	// storage depth and almost-empty default
	localparam int          DEPTH_DEF     = 1024;
	localparam int          AE_DEF_DIV    = 8;

	typedef enum logic [1:0] {MODE_ALONE, MODE_MASTER, MODE_SLAVE, MODE_PARALLEL} mode_t;

	// grouping mode from the expansion pins and strap sampled during reset
	function automatic mode_t decode_mode(input logic wx, input logic rx, input logic fl, input logic strap_n);
		if (!strap_n)
			return MODE_PARALLEL;
		else if (!wx && !rx)
			return MODE_ALONE;
		else if (!fl)
			return MODE_MASTER;
		else
			return MODE_SLAVE;
	endfunction

	// offset after reset: one eighth of the storage, less one
	function automatic int ae_default(input int depth);
		return depth / AE_DEF_DIV - 1;
	endfunction
endpackage
`default_nettype wire

//--- ae_flag.sv
/*
 * almost-empty flag register with compatible and synchronous update modes
 * assumes fill and offset come from flops in the same clock domain
 */
`timescale 1ns/1ps
`default_nettype none
module ae_flag
	import rdflag_pkg::*;
#(
	parameter int AW = 10
)(
	input  wire logic          clk_sys,
	input  wire logic          clear,
	input  wire logic          sync_mode,
	input  wire logic          rd_evt,
	input  wire logic          wr_evt,
	input  wire logic [AW:0]   fill,
	input  wire logic [AW:0]   offset,
	output logic               flag_n
);
	logic low_now;

	// fill below offset plus one means almost empty
	assign low_now = (fill <= offset);

	////////////////////////////////////////////////////////////////
	// falls on read side, rises on write side unless synchronous
	always_ff @(posedge clk_sys) begin
		if (clear) begin
			flag_n <= 1'b0;
		end else if (sync_mode) begin
			if (rd_evt) begin
				flag_n <= !low_now;
			end
		end else if (rd_evt && low_now) begin
			flag_n <= 1'b0;
		end else if (wr_evt && !low_now) begin
			flag_n <= 1'b1;
		end
	end
endmodule
`default_nettype wire

//--- read_token.sv
/*
 * read token holder for cascaded rings
 * assumes token input is synchronous and pulses low for at least one cycle
 */
`timescale 1ns/1ps
`default_nettype none
module read_token
	import rdflag_pkg::*;
(
	input  wire logic   clk_sys,
	input  wire logic   clear,
	input  wire mode_t  mode,
	input  wire logic   token_in_n,
	input  wire logic   last_read,
	output logic        have_token,
	output logic        token_out_n
);
	logic  in_q;
	logic  got;
	logic  cascaded;

	assign cascaded = (mode == MODE_MASTER) || (mode == MODE_SLAVE);
	// a low-going edge on the ring input hands the token over
	assign got = in_q && !token_in_n;

	////////////////////////////////////////////////////////////////
	// previous level of the ring input
	always_ff @(posedge clk_sys) begin
		if (clear) begin
			in_q <= 1'b1;
		end else begin
			in_q <= token_in_n;
		end
	end

	// one-cycle low pulse after the last location is read
	always_ff @(posedge clk_sys) begin
		if (clear || !cascaded) begin
			token_out_n <= 1'b1;
		end else begin
			token_out_n <= !last_read;
		end
	end

	// master starts holding the token, slaves wait for it
	always_ff @(posedge clk_sys) begin
		if (clear) begin
			have_token <= (mode != MODE_SLAVE);
		end else if (!cascaded) begin
			have_token <= 1'b1;
		end else if (last_read) begin
			have_token <= 1'b0;
		end else if (got) begin
			have_token <= 1'b1;
		end
	end
endmodule
`default_nettype wire

//--- fifo_read_flags.sv
/*
 * read-side status of a cascadable fifo: empty and almost-empty flags,
 * read pointer, read token and output drive, with an apb register slave
 * assumes write_commit pulses once per stored word from the write side,
 * read_clock_edge marks read-clock rising edges, all pins synchronous
 */
`timescale 1ns/1ps
`default_nettype none
module fifo_read_flags
	import rdflag_pkg::*;
#(
	parameter int DEPTH = DEPTH_DEF
)(
	input  wire logic                      clk_sys,
	input  wire logic                      srst,
	input  wire logic [7:0]                paddr,
	input  wire logic                      psel,
	input  wire logic                      penable,
	input  wire logic                      pwrite,
	input  wire logic [31:0]               pwdata,
	output logic      [31:0]               prdata,
	output logic                           pready,
	output logic                           pslverr,
	input  wire logic                      master_reset_n,
	input  wire logic                      read_clock_edge,
	input  wire logic                      read_enable_n,
	input  wire logic                      read_token_in_or_second_read_enable,
	input  wire logic                      write_token_in_or_second_write_enable,
	input  wire logic                      first_load_or_retransmit,
	input  wire logic                      enhanced_mode_strap_n,
	input  wire logic                      output_enable_n,
	input  wire logic                      write_commit,
	output logic                           almost_empty_flag_n,
	output logic                           empty_flag_n,
	output logic                           read_token_out_n,
	output logic                           read_strobe,
	output logic      [$clog2(DEPTH)-1:0]  read_addr,
	output logic                           data_out_en,
	output logic                           irq
);
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0]   AE_RESET = (AW+1)'(ae_default(DEPTH));
	localparam logic [AW:0]   DEPTH_W  = (AW+1)'(DEPTH);
	localparam logic [AW-1:0] LAST_LOC = (AW)'(DEPTH - 1);

	generate
		if (DEPTH != 512 && DEPTH != 1024) begin : g_bad_depth
			$error("fifo_read_flags: DEPTH must be 512 or 1024");
		end
	endgenerate

	////////////////////////////////////////////////////////////////
	// declarations
	logic                in_reset;
	mode_t               mode;
	logic [CMD_W-1:0]    cmd;
	logic [AW:0]         ae_offset;
	logic [AW:0]         wptr;
	logic [AW:0]         rptr;
	logic [AW:0]         fill;
	logic [AW:0]         fill_after;
	logic                full;
	logic                wr_ok;
	logic                second_ok;
	logic                have_token;
	logic                do_read;
	logic                last_read;
	logic                re_q;
	logic                wr_q;
	logic                ef_q;
	logic                ae_q;
	logic [NUM_EV-1:0]   events;
	logic [NUM_EV-1:0]   irq_stat;
	logic [NUM_EV-1:0]   irq_en;
	logic                wr_acc;
	logic                rd_setup;
	logic                mapped;
	logic [31:0]         next_prdata;

	// master reset pin and system reset both restart the fifo
	assign in_reset = srst || !master_reset_n;

	////////////////////////////////////////////////////////////////
	// grouping mode, caught by a clocked process while reset holds
	always_ff @(posedge clk_sys) begin
		if (in_reset) begin
			mode <= decode_mode(write_token_in_or_second_write_enable,
				read_token_in_or_second_read_enable,
				first_load_or_retransmit, enhanced_mode_strap_n);
		end
	end

	////////////////////////////////////////////////////////////////
	// apb decode; the slave answers in the first access cycle
	assign wr_acc   = psel && penable && pready && pwrite;
	assign rd_setup = psel && !penable;

	always_comb begin
		mapped = 1'b1;
		next_prdata = 32'h0000_0000;
		case (paddr)
			ADDR_CMD: begin
				next_prdata[CMD_W-1:0] = cmd;
			end
			ADDR_AE_OFS: begin
				next_prdata[AW:0] = ae_offset;
			end
			ADDR_STATUS: begin
				next_prdata[0] = empty_flag_n;
				next_prdata[1] = almost_empty_flag_n;
				next_prdata[2] = have_token;
				next_prdata[4:3] = mode;
				next_prdata[16 +: AW+1] = fill;
			end
			ADDR_IRQ_STAT: begin
				next_prdata[NUM_EV-1:0] = irq_stat;
			end
			ADDR_IRQ_CLR: begin
				next_prdata = 32'h0000_0000; // write only
			end
			ADDR_IRQ_EN: begin
				next_prdata[NUM_EV-1:0] = irq_en;
			end
			default: begin
				mapped = 1'b0;
			end
		endcase
	end

	// ready and read data are set up during the setup cycle
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else begin
			pready  <= rd_setup;
			pslverr <= rd_setup && !mapped;
			prdata  <= rd_setup ? next_prdata : 32'h0000_0000;
		end
	end

	////////////////////////////////////////////////////////////////
	// command register; the strap forces the enhanced bits in reset

	always_ff @(posedge clk_sys) begin
		if (in_reset) begin
			cmd <= CMD_RESET;
			cmd[CMD_STRAP_MSB:CMD_STRAP_LSB] <= enhanced_mode_strap_n ?
				STRAP_CLEAR : STRAP_FORCED;
		end else if (wr_acc && paddr == ADDR_CMD) begin
			cmd <= pwdata[CMD_W-1:0];
		end
	end

	// offset values beyond the storage depth are ignored
	always_ff @(posedge clk_sys) begin
		if (in_reset) begin
			ae_offset <= AE_RESET;
		end else if (wr_acc && paddr == ADDR_AE_OFS &&
			pwdata[31:0] <= 32'(DEPTH)) begin
			ae_offset <= pwdata[AW:0];
		end
	end

	////////////////////////////////////////////////////////////////
	// pointers; the extra top bit tells full from empty
	assign fill       = wptr - rptr;
	assign full       = (fill == DEPTH_W);
	assign wr_ok      = write_commit && !full;
	// the second enable is active low outside cascaded modes
	assign second_ok  = (mode == MODE_MASTER) || (mode == MODE_SLAVE) ||
		!read_token_in_or_second_read_enable;
	assign do_read    = read_clock_edge && !read_enable_n && empty_flag_n &&
		have_token && second_ok;
	assign last_read  = do_read && (rptr[AW-1:0] == LAST_LOC);
	assign fill_after = fill - (AW+1)'(do_read);

	always_ff @(posedge clk_sys) begin
		if (in_reset) begin
			wptr <= '0;
		end else if (wr_ok) begin
			wptr <= wptr + 1'b1;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (in_reset) begin
			rptr <= '0;
		end else if (do_read) begin
			rptr <= rptr + 1'b1;
		end
	end

	assign read_addr = rptr[AW-1:0];

	// read strobe marks the cycle after an accepted read
	always_ff @(posedge clk_sys) begin
		if (in_reset) begin
			read_strobe <= 1'b0;
		end else begin
			read_strobe <= do_read;
		end
	end

	////////////////////////////////////////////////////////////////
	// empty flag, only touched on read-clock edges

	always_ff @(posedge clk_sys) begin
		if (in_reset) begin
			empty_flag_n <= 1'b0;
		end else if (read_clock_edge) begin
			empty_flag_n <= (fill_after != '0);
		end
	end

	////////////////////////////////////////////////////////////////
	// almost-empty flag; events delayed so they line up with fill

	always_ff @(posedge clk_sys) begin
		if (in_reset) begin
			re_q <= 1'b0;
			wr_q <= 1'b0;
		end else begin
			re_q <= read_clock_edge;
			wr_q <= wr_ok;
		end
	end

	ae_flag #(
		.AW (AW)
	) u_ae_flag (
		.clk_sys   (clk_sys),
		.clear     (in_reset),
		.sync_mode (cmd[CMD_AE_SYNC]),
		.rd_evt    (re_q),
		.wr_evt    (wr_q),
		.fill      (fill),
		.offset    (ae_offset),
		.flag_n    (almost_empty_flag_n)
	);

	////////////////////////////////////////////////////////////////
	// read token and output drive

	read_token u_read_token (
		.clk_sys     (clk_sys),
		.clear       (in_reset),
		.mode        (mode),
		.token_in_n  (read_token_in_or_second_read_enable),
		.last_read   (last_read),
		.have_token  (have_token),
		.token_out_n (read_token_out_n)
	);

	// outputs stay off without the token, whatever the enable pin says
	always_ff @(posedge clk_sys) begin
		if (in_reset) begin
			data_out_en <= 1'b0;
		end else begin
			data_out_en <= !output_enable_n && have_token && !last_read;
		end
	end

	////////////////////////////////////////////////////////////////
	// interrupts; a new event beats a clear in the same cycle

	always_ff @(posedge clk_sys) begin
		if (in_reset) begin
			ef_q <= 1'b0;
			ae_q <= 1'b0;
		end else begin
			ef_q <= empty_flag_n;
			ae_q <= almost_empty_flag_n;
		end
	end

	assign events[EV_EMPTY]  = ef_q && !empty_flag_n;
	assign events[EV_AEMPTY] = ae_q && !almost_empty_flag_n;
	assign events[EV_TOKEN]  = !read_token_out_n;

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			irq_stat <= '0;
		end else if (wr_acc && paddr == ADDR_IRQ_CLR) begin
			irq_stat <= (irq_stat & ~pwdata[NUM_EV-1:0]) | events;
		end else begin
			irq_stat <= irq_stat | events;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			irq_en <= IRQ_EN_RESET;
		end else if (wr_acc && paddr == ADDR_IRQ_EN) begin
			irq_en <= pwdata[NUM_EV-1:0];
		end
	end

	// registered, so the line follows status one cycle late
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			irq <= 1'b0;
		end else begin
			irq <= |(irq_stat & irq_en);
		end
	end

	////////////////////////////////////////////////////////////////
	// checks
	no_read_empty_a: assert property (@(posedge clk_sys) disable iff (srst)
		read_strobe |-> $past(empty_flag_n))
		else $error("read taken while empty flag low");
	ef_edge_a: assert property (@(posedge clk_sys) disable iff (srst)
		(!$stable(empty_flag_n) && !$past(in_reset)) |-> $past(read_clock_edge))
		else $error("empty flag moved without read edge");
	ae_sync_a: assert property (@(posedge clk_sys) disable iff (srst)
		($past(cmd[CMD_AE_SYNC]) && !$past(in_reset) && !$stable(almost_empty_flag_n))
		|-> $past(re_q))
		else $error("synchronous almost-empty moved off read edge");
	ae_fall_a: assert property (@(posedge clk_sys) disable iff (srst)
		($fell(almost_empty_flag_n) && !$past(in_reset)) |-> $past(re_q))
		else $error("almost-empty fell without read edge");
	ae_rise_a: assert property (@(posedge clk_sys) disable iff (srst)
		($rose(almost_empty_flag_n) && !$past(cmd[CMD_AE_SYNC])) |-> $past(wr_q))
		else $error("compatible almost-empty rose without write");
	token_pulse_a: assert property (@(posedge clk_sys) disable iff (srst)
		$fell(read_token_out_n) |=> read_token_out_n)
		else $error("token pulse longer than one cycle");
	alone_token_a: assert property (@(posedge clk_sys) disable iff (srst)
		(mode == MODE_ALONE && !$past(in_reset)) |-> read_token_out_n)
		else $error("standalone token output asserted");
	token_hiz_a: assert property (@(posedge clk_sys) disable iff (srst)
		!read_token_out_n |-> !data_out_en)
		else $error("outputs driven after token pulse");
	reset_flags_a: assert property (@(posedge clk_sys) disable iff (srst)
		$past(in_reset) |-> (!empty_flag_n && !almost_empty_flag_n && fill == '0))
		else $error("flags or pointers not cleared by reset");
	strap_cmd_a: assert property (@(posedge clk_sys) disable iff (srst)
		($past(in_reset) && !$past(enhanced_mode_strap_n))
		|-> cmd[CMD_STRAP_MSB:CMD_STRAP_LSB] == STRAP_FORCED)
		else $error("strap did not force command bits");
	ae_level_a: assert property (@(posedge clk_sys) disable iff (srst)
		($past(cmd[CMD_AE_SYNC]) && $past(re_q) && !$past(in_reset))
		|-> almost_empty_flag_n == ($past(fill) > $past(ae_offset)))
		else $error("almost-empty level wrong after read edge");
endmodule
`default_nettype wire

//--- ring_peer.sv
/*
 * neighbouring fifo in a read token ring: takes the token, keeps it
 * for a while, then hands it back as one low cycle
 * assumes it shares the dut clock and sits on the token pins
 */
`timescale 1ns/1ps
`default_nettype none
module ring_peer #(
	parameter int HOLD = 20
)(
	input  wire logic clk_sys,
	input  wire logic srst,
	input  wire logic token_in_n,
	output logic      token_out_n
);
	logic       prev_n;
	logic [7:0] wait_cnt;
	logic       busy;

	////////////////////////////////////////////////////////////
	// a fall on the input is the token; busy models our own reading
	always_ff @(posedge clk_sys) begin
		prev_n <= token_in_n;
		token_out_n <= 1'b1;
		if (srst) begin
			busy <= 1'b0;
			wait_cnt <= 8'h00;
		end else if (prev_n && !token_in_n) begin
			busy <= 1'b1;
			wait_cnt <= 8'h00;
		end else if (busy) begin
			wait_cnt <= wait_cnt + 8'h01;
			if (wait_cnt == HOLD[7:0]) begin
				busy <= 1'b0;
				token_out_n <= 1'b0;
			end
		end
	end
endmodule
`default_nettype wire

//--- tb_top.sv
/*
 * self-checking bench for fifo_read_flags with one ring neighbour
 * assumes the apb and read-side timing of the designer's note
 */
`timescale 1ns/1ps
`default_nettype none
module tb_top
	import rdflag_pkg::*;
;
	localparam int D = 512;
	// mode table, bit i is entry i: alone, master, slave, parallel
	localparam logic [3:0] MW = 4'h6;
	localparam logic [3:0] MF = 4'hc;
	localparam logic [3:0] MS = 4'h7;
	logic        clk_sys = 0, srst = 1, psel = 0, penable = 0, pwrite = 0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic        pready, pslverr, err;
	logic        mr_n = 1, rce = 0, ren_n = 1, ren2_n = 0, wx = 0, fl = 0, strap_n = 1;
	logic        oe_n = 0, wc = 0, ring_on = 0, peer_n, rx_pin;
	logic        ae_n, ef_n, tok_n, strobe, doe, irq;
	logic [8:0]  raddr;
	int          err_total = 0, checks = 0, cyc = 0, tok_lows = 0, strobes = 0, t0, s0;

	// in standalone the pin is a second enable, in a ring the peer drives it
	assign rx_pin = ring_on ? peer_n : ren2_n;

	fifo_read_flags #(.DEPTH(D)) i_dut (
		.clk_sys(clk_sys), .srst(srst), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.master_reset_n(mr_n), .read_clock_edge(rce), .read_enable_n(ren_n),
		.read_token_in_or_second_read_enable(rx_pin), .write_token_in_or_second_write_enable(wx),
		.first_load_or_retransmit(fl), .enhanced_mode_strap_n(strap_n), .output_enable_n(oe_n),
		.write_commit(wc), .almost_empty_flag_n(ae_n), .empty_flag_n(ef_n),
		.read_token_out_n(tok_n), .read_strobe(strobe), .read_addr(raddr), .data_out_en(doe),
		.irq(irq));

	ring_peer #(.HOLD(20)) i_peer (.clk_sys(clk_sys), .srst(srst), .token_in_n(tok_n),
		.token_out_n(peer_n));

	initial forever #25 clk_sys = ~clk_sys;

	////////////////////////////////////////////////////////////
	// counts token low cycles and read strobes; cuts a hang short
	always @(posedge clk_sys) begin
		cyc++;
		if (tok_n === 1'b0)
			tok_lows++;
		if (strobe === 1'b1)
			strobes++;
		if (cyc == 20000) begin
			err_total++;
			give_verdict();
		end
	end

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic chk_bit(input string nm, input logic e, input logic g);
		checks++;
		if (g !== e) begin
			err_total++;
			$display("CHECK FAILED %s exp %b got %b", nm, e, g);
		end
	endtask

	task automatic chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			err_total++;
			$display("CHECK FAILED %s exp %h got %h", nm, e, g);
		end
	endtask

	// one apb transfer; the wait ends only on pready or the bench timeout
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1;
		do begin
			@(posedge clk_sys);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
	endtask

	// one read clock edge, then strobe and empty flag as they stand after it
	task automatic rdedge(input logic r_n, input logic es, input logic ee);
		@(posedge clk_sys);
		rce <= 1;
		ren_n <= r_n;
		@(posedge clk_sys);
		rce <= 0;
		ren_n <= 1;
		#1;
		chk_bit("read_strobe", es, strobe);
		chk_bit("empty_flag_n", ee, ef_n);
	endtask

	// bursts leave three cycles for the two-cycle flag lag
	task automatic wr(input int n);
		@(posedge clk_sys);
		wc <= 1;
		repeat (n) @(posedge clk_sys);
		wc <= 0;
		repeat (3) @(posedge clk_sys);
		#1;
	endtask

	task automatic rdn(input int n);
		@(posedge clk_sys);
		rce <= 1;
		ren_n <= 0;
		repeat (n) @(posedge clk_sys);
		rce <= 0;
		ren_n <= 1;
		repeat (3) @(posedge clk_sys);
		#1;
	endtask

	task automatic settle();
		repeat (2) @(posedge clk_sys);
		#1;
	endtask

	task automatic rst(input logic w, input logic r, input logic f, input logic s, input logic use_mr);
		@(posedge clk_sys);
		wx <= w;
		ren2_n <= r;
		fl <= f;
		strap_n <= s;
		if (use_mr)
			mr_n <= 0;
		else
			srst <= 1;
		repeat (6) @(posedge clk_sys);
		mr_n <= 1;
		srst <= 0;
		#1;
		chk_bit("empty_flag_n", 0, ef_n);
		chk_bit("almost_empty_flag_n", 0, ae_n);
		chk_bit("read_token_out_n", 1, tok_n);
		chk_word("read_addr", 0, {23'h0, raddr});
	endtask

	////////////////////////////////////////////////////////////
	initial begin
		rst(0, 0, 0, 1, 0);
		apb(0, ADDR_AE_OFS, 0);
		chk_word("ae_offset", D / 8 - 1, rd);
		apb(0, ADDR_CMD, 0);
		chk_word("command", 0, rd);
		apb(0, ADDR_IRQ_EN, 0);
		chk_word("irq_enable", IRQ_EN_RESET, rd);
		apb(1, 8'h18, 32'hffff_ffff);
		chk_bit("slave_error", 1, err);
		apb(0, 8'h18, 0);
		chk_word("unmapped", 0, rd);
		apb(1, ADDR_IRQ_CLR, 32'h7);
		$display("test registers done");
		// empty flag waits for a read edge; refused read moves nothing
		wr(1);
		chk_bit("empty_flag_n", 0, ef_n);
		rdedge(1, 0, 1);
		rdedge(0, 1, 0);
		rdedge(0, 0, 0);
		chk_word("read_addr", 1, {23'h0, raddr});
		apb(0, ADDR_IRQ_STAT, 0);
		chk_word("irq_status", 32'h1, rd);
		chk_bit("irq", 0, irq);
		apb(1, ADDR_IRQ_EN, 32'h1);
		settle();
		chk_bit("irq", 1, irq);
		apb(1, ADDR_IRQ_CLR, 32'h1);
		settle();
		chk_bit("irq", 0, irq);
		apb(1, ADDR_IRQ_EN, 32'h0);
		$display("test empty done");
		// fill crosses the default offset both ways
		wr(D / 8 - 1);
		chk_bit("almost_empty_flag_n", 0, ae_n);
		wr(1);
		chk_bit("almost_empty_flag_n", 1, ae_n);
		// the first read edge after writes only lifts the empty flag
		rdedge(0, 0, 1);
		rdedge(0, 1, 1);
		settle();
		chk_bit("almost_empty_flag_n", 0, ae_n);
		chk_bit("data_out_en", 1, doe);
		oe_n <= 1;
		settle();
		chk_bit("data_out_en", 0, doe);
		oe_n <= 0;
		apb(1, ADDR_CMD, 32'h40);
		wr(2);
		chk_bit("almost_empty_flag_n", 0, ae_n);
		rdedge(0, 1, 1);
		settle();
		chk_bit("almost_empty_flag_n", 1, ae_n);
		apb(1, ADDR_CMD, 32'h0);
		apb(1, ADDR_AE_OFS, 600);
		apb(0, ADDR_AE_OFS, 0);
		chk_word("ae_offset", D / 8 - 1, rd);
		apb(1, ADDR_AE_OFS, D);
		apb(0, ADDR_AE_OFS, 0);
		chk_word("ae_offset", D, rd);
		apb(1, ADDR_AE_OFS, D / 8 - 1);
		$display("test almost empty done");
		// standalone passes the last location without a token pulse
		wr(D - 64);
		t0 = tok_lows;
		s0 = strobes;
		rdn(D);
		chk_word("strobes", D, strobes - s0);
		chk_word("token_lows", 0, tok_lows - t0);
		chk_word("read_addr", 3, {23'h0, raddr});
		chk_bit("empty_flag_n", 0, ef_n);
		$display("test standalone wrap done");
		for (int i = 0; i < 4; i++) begin
			rst(MW[i], MW[i], MF[i], MS[i], i == 3);
			apb(0, ADDR_STATUS, 0);
			chk_word("mode", i, {30'h0, rd[4:3]});
			chk_bit("token_held", i != 2, rd[2]);
			apb(0, ADDR_CMD, 0);
			chk_word("command", (i == 3) ? 32'h7c0 : 32'h0, rd);
		end
		$display("test modes done");
		// master in a ring: token leaves after location D-1 and comes back
		@(posedge clk_sys);
		ring_on <= 1;
		rst(1, 1, 0, 1, 0);
		wr(D);
		rdedge(1, 0, 1);
		t0 = tok_lows;
		rdn(D);
		chk_word("token_lows", 1, tok_lows - t0);
		chk_bit("data_out_en", 0, doe);
		wr(1);
		rdedge(0, 0, 1);
		repeat (30) @(posedge clk_sys);
		#1;
		chk_bit("data_out_en", 1, doe);
		rdedge(0, 1, 0);
		chk_word("read_addr", 1, {23'h0, raddr});
		$display("test ring done");
		give_verdict();
	end
endmodule
`default_nettype wire
